/* src/pelt_consts.vh */
// Purpose: Constants for the pulse event sequencer with hardware looping.
// Assumes: 20 MHz core clock (50 ns period).
// Notes:   Times are held in picoseconds; cycle counts derive from them.
`ifndef PELT_CONSTS_VH
`define PELT_CONSTS_VH

// ----------------------------------------------------------------
// Clock and time bases
// ----------------------------------------------------------------
`define PELT_CLK_PS 32'h0000C350
// Cycles per base tick at 50 ns, sized so that no 1 s count overflows 32 bits.
`define PELT_TB_FINE_CYC 32'h00000002
`define PELT_TB_US_CYC 32'h00000014
`define PELT_TB_MS_CYC 32'h00004E20
`define PELT_TB_S_CYC 32'h01312D00

// ----------------------------------------------------------------
// Time-base select codes
// ----------------------------------------------------------------
`define PELT_TB_FINE 2'h0
`define PELT_TB_US 2'h1
`define PELT_TB_MS 2'h2
`define PELT_TB_S 2'h3

// ----------------------------------------------------------------
// Interval counter limits and loop capacity
// ----------------------------------------------------------------
`define PELT_CNT_MIN 12'h002
`define PELT_CNT_MAX 12'hFFF
`define PELT_CAP_SMALL 12'h03F
`define PELT_CAP_MID 12'h400
`define PELT_CAP_LARGE 12'h800
`define PELT_BUF_DEPTH 2048
`define PELT_PTR_W 11

// ----------------------------------------------------------------
// Command word: [31:30] opcode, [29:28] base, [27:16] count,
// [15:0] gate lines or repetition count.
// ----------------------------------------------------------------
`define PELT_OP_EVENT 2'h0
`define PELT_OP_LOOP_OPEN 2'h1
`define PELT_OP_LOOP_CLOSE 2'h2
`define PELT_OP_NOP 2'h3

// ----------------------------------------------------------------
// Error status bits
// ----------------------------------------------------------------
`define PELT_ERR_ZERO 0
`define PELT_ERR_NEST 1
`define PELT_ERR_CAP 2
`define PELT_ERR_COUNT 3
`define PELT_ERR_NOLOOP 4

`endif

/* src/pelt_sequencer.v */
// Purpose: Pulse-program event sequencer with one level of hardware looping.
// Assumes: Host words arrive with a valid/ready handshake on core_clk.
// Notes:   Loop bodies are replayed from an internal body store.
`timescale 1ns/1ps
`include "pelt_consts.vh"

module pelt_sequencer #(
    parameter [11:0] LOOP_CAP = `PELT_CAP_LARGE,
    parameter LOOP_ENABLE = 1,
    parameter [31:0] TB_S_CYC = `PELT_TB_S_CYC,
    parameter [31:0] TB_MS_CYC = `PELT_TB_MS_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Pulse-program word stream from the host
    input wire [31:0] progWord,
    input wire progValid,
    output reg progReady_r,
    // Error clear from host logic
    input wire errClear,
    // Gate lines and status
    output reg [15:0] gateLines_r,
    output reg eventStart_r,
    output reg busy_r,
    output reg loopActive_r,
    output reg [4:0] errStatus_r
);

    // ----------------------------------------------------------------
    // State machine codes
    // ----------------------------------------------------------------
    localparam [1:0] ST_FETCH = 2'h0;
    localparam [1:0] ST_TIME = 2'h1;
    localparam [1:0] ST_CLOSE = 2'h2;

    reg [1:0] state_r;
    reg [31:0] bodyMem [0:`PELT_BUF_DEPTH-1];
    reg [`PELT_PTR_W:0] bodyLen_r;
    reg [`PELT_PTR_W-1:0] replayPtr_r;
    reg replaying_r;
    reg recording_r;
    reg [15:0] repCount_r;
    reg [11:0] ticksLeft_r;
    reg [31:0] baseCnt_r;
    reg [31:0] baseLen_r;
    reg fromHost_r;
    reg [31:0] curWord;
    reg [31:0] baseLenSel;
    reg [4:0] errSet;
    wire [1:0] curOp;
    wire [11:0] curCount;
    wire takeHost;

    // Current word is the host word unless a loop body is being replayed.
    always @* begin
        if (replaying_r) begin
            curWord = bodyMem[replayPtr_r];
        end else begin
            curWord = progWord;
        end
    end

    assign curOp = curWord[31:30];
    assign curCount = curWord[27:16];
    assign takeHost = progValid && progReady_r;

    // Cycles per tick of the selected base.
    // four selectable bases
    always @* begin
        case (curWord[29:28])
            `PELT_TB_FINE: baseLenSel = `PELT_TB_FINE_CYC;
            `PELT_TB_US: baseLenSel = `PELT_TB_US_CYC;
            `PELT_TB_MS: baseLenSel = TB_MS_CYC;
            `PELT_TB_S: baseLenSel = TB_S_CYC;
            default: baseLenSel = `PELT_TB_FINE_CYC;
        endcase
    end

    // ----------------------------------------------------------------
    // Error detection for the word now being taken
    // ----------------------------------------------------------------
    always @* begin
        errSet = 5'h00;
        if (state_r == ST_FETCH && takeHost && !replaying_r) begin
            if (curOp == `PELT_OP_LOOP_OPEN) begin
                if (curWord[15:0] == 16'h0000) begin
                    errSet[`PELT_ERR_ZERO] = 1'b1;
                end
                if (recording_r) begin
                    errSet[`PELT_ERR_NEST] = 1'b1;
                end
                if (LOOP_ENABLE == 0) begin
                    errSet[`PELT_ERR_NOLOOP] = 1'b1;
                end
            end
            if (curOp == `PELT_OP_EVENT && recording_r && bodyLen_r[11:0] >= LOOP_CAP) begin
                errSet[`PELT_ERR_CAP] = 1'b1;
            end
            if (curOp == `PELT_OP_EVENT && curCount != 12'h000 && curCount < `PELT_CNT_MIN) begin
                errSet[`PELT_ERR_COUNT] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sticky error status; a new error wins over a clear.
    // ----------------------------------------------------------------
    // sticky error flags
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            errStatus_r <= 5'h00;
        end else begin
            errStatus_r <= (errClear ? 5'h00 : errStatus_r) | errSet;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer: fetch, time one event, replay loop body
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_FETCH;
            progReady_r <= 1'b1;
            gateLines_r <= 16'h0000;
            eventStart_r <= 1'b0;
            busy_r <= 1'b0;
            loopActive_r <= 1'b0;
            bodyLen_r <= 12'h000;
            replayPtr_r <= 11'h000;
            replaying_r <= 1'b0;
            recording_r <= 1'b0;
            repCount_r <= 16'h0000;
            ticksLeft_r <= 12'h000;
            baseCnt_r <= 32'h00000000;
            baseLen_r <= 32'h00000001;
            fromHost_r <= 1'b0;
        end else begin
            eventStart_r <= 1'b0;
            case (state_r)
                ST_FETCH: begin
                    if (replaying_r || takeHost) begin
                        fromHost_r <= !replaying_r;
                        case (curOp)
                            `PELT_OP_EVENT: begin
                                if (curCount >= `PELT_CNT_MIN) begin
                                    gateLines_r <= curWord[15:0];
                                    eventStart_r <= 1'b1;
                                    ticksLeft_r <= curCount - 12'h001;
                                    baseLen_r <= baseLenSel;
                                    baseCnt_r <= baseLenSel - 32'h00000001;
                                    busy_r <= 1'b1;
                                    progReady_r <= 1'b0;
                                    state_r <= ST_TIME;
                                end
                                if (recording_r && !replaying_r && bodyLen_r[11:0] < LOOP_CAP) begin
                                    bodyMem[bodyLen_r[`PELT_PTR_W-1:0]] <= curWord;
                                    bodyLen_r <= bodyLen_r + 12'h001;
                                end
                                if (replaying_r) begin
                                    replayPtr_r <= replayPtr_r + 11'h001;
                                end
                            end
                            `PELT_OP_LOOP_OPEN: begin
                                if (curWord[15:0] >= 16'h0002 && !recording_r && LOOP_ENABLE != 0) begin
                                    repCount_r <= curWord[15:0] - 16'h0001;
                                    recording_r <= 1'b1;
                                    loopActive_r <= 1'b1;
                                    bodyLen_r <= 12'h000;
                                end
                            end
                            `PELT_OP_LOOP_CLOSE: begin
                                if (recording_r) begin
                                    progReady_r <= 1'b0;
                                    state_r <= ST_CLOSE;
                                end
                            end
                            default: begin
                                gateLines_r <= gateLines_r;
                            end
                        endcase
                    end
                end
                ST_TIME: begin
                    if (baseCnt_r != 32'h00000000) begin
                        baseCnt_r <= baseCnt_r - 32'h00000001;
                    end else if (ticksLeft_r != 12'h000) begin
                        ticksLeft_r <= ticksLeft_r - 12'h001;
                        baseCnt_r <= baseLen_r - 32'h00000001;
                    end else begin
                        busy_r <= 1'b0;
                        if (replaying_r && replayPtr_r == bodyLen_r[`PELT_PTR_W-1:0]) begin
                            state_r <= ST_CLOSE;
                        end else begin
                            progReady_r <= !replaying_r;
                            state_r <= ST_FETCH;
                        end
                    end
                end
                ST_CLOSE: begin
                    if (repCount_r != 16'h0000 && bodyLen_r != 12'h000) begin
                        repCount_r <= repCount_r - 16'h0001;
                        replaying_r <= 1'b1;
                        replayPtr_r <= 11'h000;
                        state_r <= ST_FETCH;
                    end else begin
                        replaying_r <= 1'b0;
                        recording_r <= 1'b0;
                        loopActive_r <= 1'b0;
                        progReady_r <= 1'b1;
                        state_r <= ST_FETCH;
                    end
                end
                default: begin
                    state_r <= ST_FETCH;
                end
            endcase
        end
    end

endmodule // pelt_sequencer

/* verif/pelt_host_model.sv */
// Purpose: Host model that feeds pulse-program words to the sequencer.
// Assumes: Words are offered at the falling edge and held until taken.
// Notes:   An idle word bus shows the inverse of the last word taken.
`timescale 1ns/1ps
module pelt_host_model (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Word stream
    input wire progReady_r,
    output reg [31:0] progWord,
    output reg progValid
);
    // Idle values at time zero.
    initial begin
        progWord = 32'h0;
        progValid = 1'b0;
    end
    // loops are spaced by the host's own waits
    // Offers one word and holds it until an edge samples ready high.
    task sendWord(input [31:0] w);
        begin
            @(negedge core_clk);
            progWord = w;
            progValid = 1'b1;
            @(posedge core_clk);
            while (progReady_r !== 1'b1) @(posedge core_clk);
            @(negedge core_clk);
            progValid = 1'b0;
            progWord = ~w;
        end
    endtask
endmodule // pelt_host_model

/* verif/pelt_sequencer_properties.sv */
// Purpose: Concurrent checks on the sequencer ports.
// Assumes: One core_clk domain with asynchronous active-low reset.
// Notes:   Busy length is judged only for live events outside loops.
`timescale 1ns/1ps
`include "pelt_consts.vh"
module pelt_sequencer_properties #(
    parameter [31:0] TB_S_CYC = 32'h0000000A,
    parameter [31:0] TB_MS_CYC = 32'h00000004
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Host side
    input wire [31:0] progWord,
    input wire progValid,
    input wire progReady_r,
    input wire errClear,
    // Sequencer outputs
    input wire [15:0] gateLines_r,
    input wire eventStart_r,
    input wire busy_r,
    input wire loopActive_r,
    input wire [4:0] errStatus_r
);
    reg [31:0] busyCnt_r;
    reg [31:0] expCyc_r;
    wire tk = progValid && progReady_r;
    wire [11:0] tc = progWord[27:16];
    wire [1:0] bs = progWord[29:28];
    // Counts busy cycles and keeps the expected length of the last event.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt_r <= 32'h0;
            expCyc_r <= 32'h0;
        end else begin
            busyCnt_r <= eventStart_r ? 32'h1 : (busy_r ? busyCnt_r + 32'h1 : 32'h0);
            if (tk && progWord[31:30] == `PELT_OP_EVENT) begin
                expCyc_r <= tc * (bs == 2'h0 ? `PELT_TB_FINE_CYC : bs == 2'h1 ? `PELT_TB_US_CYC :
                    bs == 2'h2 ? TB_MS_CYC : TB_S_CYC);
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence sTake(op);
        tk && progWord[31:30] == op;
    endsequence
    sequence sOpen;
        sTake(`PELT_OP_LOOP_OPEN);
    endsequence
    a_event_gates: assert property (sTake(`PELT_OP_EVENT) ##0 tc >= `PELT_CNT_MIN |=>
        eventStart_r && busy_r && gateLines_r == $past(progWord[15:0])) else $error("Event launch wrong.");
    a_start_pulse: assert property (eventStart_r |=> !eventStart_r [*3]) else $error("Start pulse too long.");
    a_busy_length: assert property ($fell(busy_r) && !loopActive_r && !$past(loopActive_r) |->
        busyCnt_r == expCyc_r) else $error("Interval length wrong.");
    a_bad_count: assert property (sTake(`PELT_OP_EVENT) ##0 tc == 12'h001 |=>
        errStatus_r[`PELT_ERR_COUNT] && !eventStart_r) else $error("Count one not refused.");
    a_zero_event: assert property (sTake(`PELT_OP_EVENT) ##0 tc == 12'h000 |=> !eventStart_r)
        else $error("Zero count launched.");
    a_zero_open: assert property (sOpen ##0 progWord[15:0] == 16'h0 |=> errStatus_r[`PELT_ERR_ZERO] &&
        loopActive_r == $past(loopActive_r)) else $error("Zero open not flagged.");
    a_nest_flag: assert property (sOpen ##0 loopActive_r && progWord[15:0] != 16'h0 |=>
        errStatus_r[`PELT_ERR_NEST] && loopActive_r) else $error("Nested open not flagged.");
    a_open_engage: assert property (sOpen ##0 !loopActive_r && progWord[15:0] != 16'h0 |=>
        loopActive_r == ($past(progWord[15:0]) >= 16'h2)) else $error("Loop engage wrong.");
    a_err_sticky: assert property (!errClear |=> (errStatus_r & $past(errStatus_r)) == $past(errStatus_r))
        else $error("Error bit lost.");
    a_replay_host: assert property (sTake(`PELT_OP_LOOP_CLOSE) ##0 loopActive_r |=> !progReady_r)
        else $error("Host asked during replay.");
endmodule // pelt_sequencer_properties
bind pelt_sequencer pelt_sequencer_properties #(.TB_S_CYC(TB_S_CYC), .TB_MS_CYC(TB_MS_CYC)) chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .progWord(progWord), .progValid(progValid), .progReady_r(progReady_r),
    .errClear(errClear), .gateLines_r(gateLines_r), .eventStart_r(eventStart_r), .busy_r(busy_r),
    .loopActive_r(loopActive_r), .errStatus_r(errStatus_r));

/* verif/test_pulse_event_hard_loop_timer.sv */
// Purpose: Self-checking bench for the pulse event sequencer.
// Assumes: 20 MHz core_clk, shortened second and millisecond bases.
// Notes:   Inputs change on the falling edge; the small-buffer capacity is used.
`timescale 1ns/1ps
`include "pelt_consts.vh"
module test_pulse_event_hard_loop_timer;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg errClear = 1'b0;
    wire [31:0] progWord;
    wire progValid, progReady_r, eventStart_r, busy_r, loopActive_r;
    wire [15:0] gateLines_r;
    wire [4:0] errStatus_r;
    integer nFail = 0;
    integer samplesChecked = 0;
    integer nStart = 0;
    integer cycles = 0;
    // Clock of 50 ns period.
    always #25 core_clk = ~core_clk;
    // Counts launches and cuts a hang short.
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (eventStart_r === 1'b1) nStart = nStart + 1;
        if (cycles == 30000) begin
            nFail = nFail + 1;
            report_and_stop;
        end
    end
    pelt_host_model host_u (.core_clk(core_clk), .rst_n(rst_n), .progReady_r(progReady_r), .progWord(progWord),
        .progValid(progValid));
    pelt_sequencer #(.LOOP_CAP(`PELT_CAP_SMALL), .LOOP_ENABLE(1), .TB_S_CYC(32'h0000000A), .TB_MS_CYC(32'h00000004))
    dut_u (.core_clk(core_clk), .rst_n(rst_n), .progWord(progWord), .progValid(progValid), .progReady_r(progReady_r),
        .errClear(errClear), .gateLines_r(gateLines_r), .eventStart_r(eventStart_r), .busy_r(busy_r),
        .loopActive_r(loopActive_r), .errStatus_r(errStatus_r));
    // Compares one value and counts the outcome.
    task check(input [31:0] seen, input [31:0] exp, input string what);
        begin
            samplesChecked = samplesChecked + 1;
            if (seen !== exp) begin
                nFail = nFail + 1;
                $display("FAIL at %0t: %0s seen %0h expected %0h", $time, what, seen, exp);
            end
        end
    endtask
    // Builds an event word.
    function [31:0] ev(input [1:0] b, input [11:0] c, input [15:0] g);
        ev = {`PELT_OP_EVENT, b, c, g};
    endfunction
    // Clears the sticky status with a one-cycle pulse.
    task clearErr;
        begin
            @(negedge core_clk);
            errClear = 1'b1;
            @(negedge core_clk);
            errClear = 1'b0;
            check({27'h0, errStatus_r}, 32'h0, "clear");
        end
    endtask
    // Sends one event and measures its gates and interval.
    task runEvent(input [1:0] b, input [11:0] c, input [15:0] g, input integer expCyc);
        integer n;
        begin
            host_u.sendWord(ev(b, c, g));
            check({15'h0, eventStart_r, gateLines_r}, {16'h1, g}, "launch");
            n = 0;
            while (busy_r === 1'b1) begin
                n = n + 1;
                @(negedge core_clk);
            end
            check(n, expCyc, "interval");
        end
    endtask
    // Runs a loop of two-tick events, optionally trying to nest one.
    task runLoop(input [15:0] rep, input integer nBody, input integer expStarts, input [4:0] expErr, input nest);
        integer k;
        begin
            host_u.sendWord({`PELT_OP_LOOP_OPEN, 14'h0, rep});
            check({31'h0, loopActive_r}, {31'h0, rep >= 16'h2}, "engage");
            nStart = 0;
            for (k = 0; k < nBody; k = k + 1) begin
                host_u.sendWord(ev(2'h0, 12'h002, k[15:0]));
                if (nest && k == 0) host_u.sendWord({`PELT_OP_LOOP_OPEN, 14'h0, 16'h0002});
            end
            host_u.sendWord({`PELT_OP_LOOP_CLOSE, 30'h0});
            k = 0;
            while ((loopActive_r !== 1'b0 || progReady_r !== 1'b1) && k < 5000) begin
                k = k + 1;
                @(negedge core_clk);
            end
            check(nStart, expStarts, "replay count");
            check({27'h0, errStatus_r}, {27'h0, expErr}, "loop status");
            clearErr;
            $display("Loop test of %0d repeats done", rep);
        end
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(negedge core_clk);
        check({7'h0, progReady_r, busy_r, loopActive_r, eventStart_r, gateLines_r, errStatus_r},
            32'h01000000, "reset");
        rst_n = 1'b1;
        runEvent(2'h0, `PELT_CNT_MIN, 16'h00A5, 2 * `PELT_TB_FINE_CYC);
        runEvent(2'h1, 12'h003, 16'h5A00, 3 * `PELT_TB_US_CYC);
        runEvent(2'h2, 12'h002, 16'hFFFF, 2 * 4);
        runEvent(2'h3, 12'h002, 16'h0001, 2 * 10);
        runEvent(2'h0, `PELT_CNT_MAX, 16'h1234, 4095 * `PELT_TB_FINE_CYC);
        $display("Event tests done");
        host_u.sendWord(ev(2'h0, 12'h000, 16'h00FF));
        check({31'h0, eventStart_r}, 32'h0, "zero segment");
        host_u.sendWord(ev(2'h0, 12'h001, 16'h00FF));
        check({27'h0, errStatus_r}, 32'h8, "count one");
        host_u.sendWord({`PELT_OP_LOOP_OPEN, 14'h0, 16'h0000});
        check({26'h0, loopActive_r, errStatus_r}, 32'h9, "zero open");
        clearErr;
        $display("Refusal tests done");
        // bodies of two or more short events
        runLoop(16'h3, 2, 6, 5'h00, 1'b0);
        runLoop(16'h1, 2, 2, 5'h00, 1'b0);
        runLoop(16'h3, 2, 6, 5'h02, 1'b1);
        runLoop(16'h2, 63, 126, 5'h00, 1'b0);
        runLoop(16'h2, 64, 127, 5'h04, 1'b0);
        report_and_stop;
    end
    // Prints the counts and the verdict, then ends the run.
    task report_and_stop;
        begin
            $display("Checks %0d, mismatches %0d", samplesChecked, nFail);
            if (nFail == 0 && samplesChecked > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
endmodule // test_pulse_event_hard_loop_timer
